// *** sdis_pkg.sv ***
package sdis_pkg;

	// command encoding {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDIS_CMD_MRS = 4'h0,
		SDIS_CMD_REF = 4'h1,
		SDIS_CMD_PRE = 4'h2,
		SDIS_CMD_ACT = 4'h3,
		SDIS_CMD_WR = 4'h4,
		SDIS_CMD_RD = 4'h5,
		SDIS_CMD_BST = 4'h6,
		SDIS_CMD_NOP = 4'h7
	} sdis_cmd_e;

	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic a10;
	} sdis_pins_s;

	typedef enum logic [2:0] {
		SDIS_ST_POWERUP = 3'h0,
		SDIS_ST_WAIT_PRE = 3'h1,
		SDIS_ST_CONFIG = 3'h2,
		SDIS_ST_READY = 3'h3,
		SDIS_ST_SELF_REF = 3'h4
	} sdis_state_e;

	localparam int SDIS_CLK_NS = 20;
	localparam int SDIS_MIN_INIT_REF = 2;
	localparam logic [1:0] SDIS_INIT_REF_W1 = 2'h2;
	localparam int SDIS_REF_INTERVAL_NS = 15600;
	localparam int SDIS_REF_INTERVAL_CYC = SDIS_REF_INTERVAL_NS / SDIS_CLK_NS;
	localparam logic [9:0] SDIS_REF_RELOAD = 10'(SDIS_REF_INTERVAL_CYC - 1);
	localparam logic [11:0] SDIS_MODE_RESET = 12'h000;

endpackage

// *** sdis_self_ref_timer.sv ***
`timescale 1ns/1ps
// internal refresh tick generator, free running while enabled
module sdis_self_ref_timer
	import sdis_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic enable_i,
	output logic tick_o
);

	logic [9:0] count;
	logic [9:0] next_count;
	logic tick;
	logic next_tick;

	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!enable_i) begin
			next_count = SDIS_REF_RELOAD;
		end else if (count == 10'h000) begin
			next_count = SDIS_REF_RELOAD;
			next_tick = 1'b1;
		end else begin
			next_count = count - 10'h001;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= SDIS_REF_RELOAD;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

	assign tick_o = tick;

endmodule

// *** sdis_init_self_ref.sv ***
`timescale 1ns/1ps
// Function
// - refreshes accepted before or after mode set
// - CS RAS CAS low with CKE falling from high to low enters self-refresh from ready
// - one cycle later ignore all but CKE
// - stay self-refreshing while CKE stays low
module sdis_init_self_ref
	import sdis_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic a10_i,
	input wire logic [11:0] mode_i,
	output logic init_done_o,
	output logic mode_set_o,
	output logic [1:0] init_ref_count_o,
	output logic self_ref_o,
	output logic ref_tick_o,
	output logic [11:0] mode_o,
	output logic [2:0] state_o
);

	sdis_pins_s pins;
	sdis_cmd_e cmd;
	sdis_state_e state;
	sdis_state_e next_state;
	logic prev_cke;
	logic next_prev_cke;
	logic mode_set;
	logic next_mode_set;
	logic [1:0] ref_count;
	logic [1:0] next_ref_count;
	logic [11:0] mode;
	logic [11:0] next_mode;
	logic sr_active;
	logic tick;

	assign pins = '{cke: cke_i, cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i,
		we_n: we_n_i, a10: a10_i};
	assign cmd = sdis_cmd_e'({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});

	// entry needs CKE sampled low now and high on the previous edge
	logic sr_entry;
	assign sr_entry = prev_cke && !pins.cke && !pins.cs_n && !pins.ras_n
		&& !pins.cas_n;

	always_comb begin
		next_state = state;
		next_mode_set = mode_set;
		next_ref_count = ref_count;
		next_mode = mode;
		next_prev_cke = pins.cke;
		case (state)
			// no reset pin: wait for the controller to raise CKE
			SDIS_ST_POWERUP: begin
				if (pins.cke && prev_cke) begin
					next_state = SDIS_ST_WAIT_PRE;
				end
			end
			SDIS_ST_WAIT_PRE: begin
				if (pins.cke && cmd == SDIS_CMD_PRE && pins.a10) begin
					next_state = SDIS_ST_CONFIG;
				end
			end
			SDIS_ST_CONFIG: begin
				// either order of mode set and refreshes is taken
				if (pins.cke && cmd == SDIS_CMD_MRS) begin
					next_mode = mode_i;
					next_mode_set = 1'b1;
				end
				if (pins.cke && cmd == SDIS_CMD_REF && ref_count != SDIS_INIT_REF_W1) begin
					next_ref_count = ref_count + 2'h1;
				end
				if (next_mode_set && next_ref_count == SDIS_INIT_REF_W1) begin
					next_state = SDIS_ST_READY;
				end
			end
			SDIS_ST_READY: begin
				if (sr_entry) begin
					next_state = SDIS_ST_SELF_REF;
				end else if (pins.cke && cmd == SDIS_CMD_MRS) begin
					next_mode = mode_i;
				end
			end
			SDIS_ST_SELF_REF: begin
				// only CKE is looked at here, other pins don't care
				if (pins.cke) begin
					next_state = SDIS_ST_READY;
				end
			end
			default: begin
				next_state = SDIS_ST_POWERUP;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= SDIS_ST_POWERUP;
			prev_cke <= 1'b0;
			mode_set <= 1'b0;
			ref_count <= 2'h0;
			mode <= SDIS_MODE_RESET;
		end else begin
			state <= next_state;
			prev_cke <= next_prev_cke;
			mode_set <= next_mode_set;
			ref_count <= next_ref_count;
			mode <= next_mode;
		end
	end

	assign sr_active = (state == SDIS_ST_SELF_REF);

	// internal refresh runs only while self-refreshing
	sdis_self_ref_timer u_timer (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.enable_i(sr_active),
		.tick_o(tick)
	);

	logic init_done_q;
	logic self_ref_q;
	logic tick_q;
	logic [2:0] state_q;
	logic next_init_done;
	logic next_self_ref;

	// status flags follow the next state so they line up with state_o
	always_comb begin
		next_init_done = (next_state == SDIS_ST_READY) || (next_state == SDIS_ST_SELF_REF);
		next_self_ref = (next_state == SDIS_ST_SELF_REF);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			init_done_q <= 1'b0;
			self_ref_q <= 1'b0;
			tick_q <= 1'b0;
			state_q <= 3'h0;
		end else begin
			init_done_q <= next_init_done;
			self_ref_q <= next_self_ref;
			tick_q <= tick;
			state_q <= next_state;
		end
	end

	assign init_done_o = init_done_q;
	assign self_ref_o = self_ref_q;
	assign ref_tick_o = tick_q;
	assign state_o = state_q;
	assign mode_set_o = mode_set;
	assign init_ref_count_o = ref_count;
	assign mode_o = mode;

	a_sr_entry_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_READY && sr_entry) |=> (state == SDIS_ST_SELF_REF && self_ref_o))
		else $error("self-refresh not entered on entry command");

	a_sr_hold_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_SELF_REF && !cke_i) |=> (state == SDIS_ST_SELF_REF))
		else $error("left self-refresh while CKE low");

	a_sr_ignore_cmd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_SELF_REF && !cke_i)
		|=> ($stable(mode) && $stable(mode_set) && $stable(ref_count) && init_done_o))
		else $error("inputs acted on during self-refresh");

	a_sr_exit_ready: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_SELF_REF && cke_i) |=> (state == SDIS_ST_READY && !self_ref_o))
		else $error("self-refresh exit not taken");

	a_init_ref_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$rose(init_done_o) |-> (ref_count == SDIS_INIT_REF_W1 && mode_set))
		else $error("init completed without two refreshes and mode set");

	a_powerup_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_POWERUP && !(cke_i && prev_cke)) |=> (state == SDIS_ST_POWERUP))
		else $error("initialization started without CKE held high");

	a_precharge_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_WAIT_PRE && !(cke_i && cmd == SDIS_CMD_PRE && a10_i))
		|=> (state == SDIS_ST_WAIT_PRE))
		else $error("initialization advanced without precharge all");

	a_mode_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(state == SDIS_ST_CONFIG && cke_i && cmd == SDIS_CMD_MRS) |=> (mode == $past(mode_i)))
		else $error("mode register not loaded");

	sequence s_ref_in_config;
		state == SDIS_ST_CONFIG && cke_i && cmd == SDIS_CMD_REF;
	endsequence
	sequence s_mrs_in_config;
		state == SDIS_ST_CONFIG && cke_i && cmd == SDIS_CMD_MRS;
	endsequence
	sequence s_two_refs;
		(s_ref_in_config and (!mode_set)) ##1 s_ref_in_config;
	endsequence

	a_ref_before_mrs: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_two_refs ##[1:2] s_mrs_in_config |=> init_done_o)
		else $error("refreshes before mode set not accepted");

	a_mrs_before_ref: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_mrs_in_config ##1 s_ref_in_config ##[1:2] s_ref_in_config |=> init_done_o)
		else $error("refreshes after mode set not accepted");

	a_tick_only_sr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		tick |-> $past(sr_active))
		else $error("internal refresh outside self-refresh");

endmodule

// *** sdis_ctl_model.sv ***
`timescale 1ns/1ps
// controller stand-in: drives one command per edge, changed just after the edge
module sdis_ctl_model
	import sdis_pkg::*;
(
	input wire logic clk_i,
	output sdis_pins_s pins_o,
	output logic [11:0] mode_o
);
	// no byte mask pins modelled: masks count as held high throughout
	// command stays on the pins until the next call, so back-to-back is possible
	task automatic issue(input logic cke, input logic [3:0] cmd, input logic a10,
		input logic [11:0] mode);
		pins_o = {cke, cmd, a10};
		mode_o = mode;
		@(posedge clk_i);
		#2;
	endtask
endmodule

// *** sdis_init_self_ref_bench.sv ***
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("ERROR %s expected %0h seen %0h", name, exp, got); \
		end \
	end
module sdis_init_self_ref_bench
	import sdis_pkg::*;
;
	logic clk_i = 1'b0;
	logic arst_n_i;
	sdis_pins_s pins;
	logic [11:0] mode;
	logic init_done, mode_set, self_ref, tick;
	logic [1:0] ref_cnt;
	logic [11:0] mode_q;
	logic [2:0] state;
	int failures = 0;
	int samples_checked = 0;
	always #10 clk_i = ~clk_i;
	sdis_ctl_model ctl (.clk_i(clk_i), .pins_o(pins), .mode_o(mode));
	sdis_init_self_ref uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cke_i(pins.cke),
		.cs_n_i(pins.cs_n), .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n),
		.we_n_i(pins.we_n), .a10_i(pins.a10), .mode_i(mode), .init_done_o(init_done),
		.mode_set_o(mode_set), .init_ref_count_o(ref_cnt), .self_ref_o(self_ref),
		.ref_tick_o(tick), .mode_o(mode_q), .state_o(state));
	task automatic complete_run();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic no_operation_command(input logic cke);
		ctl.issue(cke, SDIS_CMD_NOP, 1'b0, 12'h000);
	endtask
	// reset stands for power-up; works mid-run too
	task automatic power_up();
		arst_n_i = 1'b0;
		no_operation_command(1'b0);
		repeat (3) @(posedge clk_i);
		#2;
		arst_n_i = 1'b1;
		`CHECK("state", SDIS_ST_POWERUP, state)
		`CHECK("init_done", 1'b0, init_done)
		`CHECK("mode", 12'h000, mode_q)
		repeat (200000 / SDIS_CLK_NS) no_operation_command(1'b0); // full 200 us of stable clock
		repeat (3) no_operation_command(1'b1);
		`CHECK("state", SDIS_ST_WAIT_PRE, state)
		// one-bank precharge and an early refresh must not advance
		ctl.issue(1'b1, SDIS_CMD_REF, 1'b0, 12'h000);
		ctl.issue(1'b1, SDIS_CMD_PRE, 1'b0, 12'h000);
		no_operation_command(1'b1);
		`CHECK("state", SDIS_ST_WAIT_PRE, state)
		`CHECK("ref_cnt", 2'h0, ref_cnt)
		ctl.issue(1'b1, SDIS_CMD_PRE, 1'b1, 12'h000);
		no_operation_command(1'b1);
		`CHECK("state", SDIS_ST_CONFIG, state)
	endtask
	task automatic sc_ref_first();
		power_up();
		ctl.issue(1'b1, SDIS_CMD_REF, 1'b0, 12'h000);
		ctl.issue(1'b1, SDIS_CMD_REF, 1'b0, 12'h000);
		no_operation_command(1'b1);
		`CHECK("ref_cnt", 2'h2, ref_cnt)
		`CHECK("init_done", 1'b0, init_done)
		ctl.issue(1'b1, SDIS_CMD_MRS, 1'b0, 12'h5A5);
		no_operation_command(1'b1);
		`CHECK("init_done", 1'b1, init_done)
		`CHECK("mode_set", 1'b1, mode_set)
		`CHECK("mode", 12'h5A5, mode_q)
	endtask
	task automatic sc_mrs_first();
		power_up();
		ctl.issue(1'b1, SDIS_CMD_MRS, 1'b0, 12'h3C3);
		ctl.issue(1'b1, SDIS_CMD_REF, 1'b0, 12'h000);
		no_operation_command(1'b1);
		`CHECK("init_done", 1'b0, init_done)
		ctl.issue(1'b1, SDIS_CMD_REF, 1'b0, 12'h000);
		no_operation_command(1'b1);
		`CHECK("init_done", 1'b1, init_done)
		`CHECK("state", SDIS_ST_READY, state)
	endtask
	// burst refresher: each refresh spaced by the slower row cycle time
	task automatic ref_burst();
		repeat (4096) begin
			ctl.issue(1'b1, SDIS_CMD_REF, 1'b0, 12'h000);
			repeat (2) no_operation_command(1'b1);
		end
	endtask
	task automatic sc_self_ref();
		int n;
		ref_burst();
		no_operation_command(1'b1);
		ctl.issue(1'b0, SDIS_CMD_REF, 1'b0, 12'h000); // we high, banks idle
		no_operation_command(1'b0);
		`CHECK("self_ref", 1'b1, self_ref)
		ctl.issue(1'b0, SDIS_CMD_MRS, 1'b1, 12'hFFF);
		no_operation_command(1'b0);
		`CHECK("mode", 12'h3C3, mode_q)
		// stays in self-refresh far beyond the row-active time
		n = 0;
		while (tick !== 1'b1 && n < 800) begin
			no_operation_command(1'b0);
			n++;
		end
		`CHECK("tick", 1'b1, tick)
		if (n == 800) complete_run();
		`CHECK("self_ref", 1'b1, self_ref)
		ctl.issue(1'b1, 4'hF, 1'b0, 12'h000);
		repeat (4) no_operation_command(1'b1); // 80 ns covers row cycle plus setup
		`CHECK("self_ref", 1'b0, self_ref)
		`CHECK("state", SDIS_ST_READY, state)
		ref_burst();
		`CHECK("state", SDIS_ST_READY, state)
		`CHECK("init_done", 1'b1, init_done)
	endtask
	// no activate, read or write is ever issued
	initial begin
		sc_ref_first();
		sc_mrs_first();
		sc_self_ref();
		complete_run();
	end
endmodule
